// [sci_pkg.sv]
// constants and types shared by the skip/compare instruction logic
package sci_pkg;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam int INSTR_W = 10;
  localparam int NIB_W = 4;
  localparam logic [9:0] OPC_SKIP_IMM_W1 = 10'h025;
  localparam logic [9:0] OPC_SKIP_MEM = 10'h026;
  localparam logic [9:0] OPC_SKIP_EXT0 = 10'h038;
  localparam logic [9:0] OPC_SKIP_EXT1 = 10'h039;
  localparam logic [5:0] IMM_PREFIX = 6'h07;
  localparam int IMM_LSB = 0;
  localparam int PREFIX_LSB = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_FLAGS = 4'h4;
  localparam logic [3:0] ADR_SKIPCNT = 4'h8;
  localparam int CTRL_EN0_BIT = 0;
  localparam int CTRL_EN1_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int FLAG0_BIT = 0;
  localparam int FLAG1_BIT = 1;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_IMM = 3'b010,
    ST_SKIP = 3'b100
  } sci_state_t;

endpackage : sci_pkg

// [sci_pin_sync.sv]
// three-stage synchroniser and rising-edge detector for request pins
`timescale 1ns/1ps
`default_nettype none
module sci_pin_sync
  import sci_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] rise_o
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff;
  logic [W-1:0] nxt_lvl, nxt_rise;

  // ----------------------------------------------------------------
  // a change counts once stages two and three agree
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        nxt_lvl[g] = lvl_ff[g];
        nxt_rise[g] = 1'b0;
        if (s2_ff[g] == s3_ff[g]) begin
          nxt_lvl[g] = s3_ff[g];
          nxt_rise[g] = s3_ff[g] & ~lvl_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
      rise_ff <= '0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_rise;
    end
  end

  assign rise_o = rise_ff;

endmodule : sci_pin_sync
`default_nettype wire

// [sci_wb_regs.sv]
// classic wishbone slave holding the control and status registers
`timescale 1ns/1ps
`default_nettype none
module sci_wb_regs
  import sci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] flags_i,
  input wire logic [CNT_W-1:0] skip_cnt_i,
  output logic [1:0] en_o,
  output logic [1:0] flag_clr_o
);

  logic ack_ff, nxt_ack;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] dat_ff, nxt_dat;
  logic req, wr_lo;

  // ----------------------------------------------------------------
  // decode; answer one cycle after the request, writes land on the acked edge
  // ----------------------------------------------------------------
  always_comb begin
    req = cyc_i & stb_i & ~ack_ff;
    wr_lo = cyc_i & stb_i & ack_ff & we_i & sel_i[0];
    nxt_ack = req;
    nxt_ctrl = ctrl_ff;
    nxt_dat = dat_ff;
    flag_clr_o = 2'h0;
    if (wr_lo && adr_i == ADR_CTRL) begin
      nxt_ctrl = dat_i[1:0];
    end
    if (wr_lo && adr_i == ADR_FLAGS) begin
      flag_clr_o = dat_i[1:0];
    end
    if (req && !we_i) begin
      unique case (adr_i)
        ADR_CTRL: nxt_dat = {30'h0, ctrl_ff};
        ADR_FLAGS: nxt_dat = {30'h0, flags_i};
        ADR_SKIPCNT: nxt_dat = {24'h0, skip_cnt_i};
        default: nxt_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      ctrl_ff <= CTRL_RST;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      ctrl_ff <= nxt_ctrl;
      dat_ff <= nxt_dat;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign en_o = ctrl_ff;

endmodule : sci_wb_regs
`default_nettype wire

// [sci_core.sv]
// execution logic of the compare-and-skip and request-flag-test instructions
// Function
// - skip next when accumulator equals immediate
// - accumulator differs from immediate: execute next
// - immediate word is 000111nnnn, value low bits
// - skip next when accumulator equals memory nibble
// - enable0 low, flag0 set: skip, clear flag0
// - enable0 high: flag0 test is no-operation
// - enable1 low, flag1 set: skip, clear flag1
// - accumulator differs from memory: execute next
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sci_core
  import sci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_word_i,
  input wire logic [NIB_W-1:0] acc_i,
  input wire logic [NIB_W-1:0] mem_nibble_i,
  // external request pins
  input wire logic ext0_pin_i,
  input wire logic ext1_pin_i,
  // outcome
  output logic skip_o,
  output logic discard_o,
  output logic ext0_request_flag_o,
  output logic ext1_request_flag_o,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_imm_word(input logic [INSTR_W-1:0] w);
    return w[INSTR_W-1:PREFIX_LSB] == IMM_PREFIX;
  endfunction : is_imm_word

  function automatic logic [NIB_W-1:0] imm_of(input logic [INSTR_W-1:0] w);
    return w[IMM_LSB+NIB_W-1:IMM_LSB];
  endfunction : imm_of

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sci_state_t state_ff, nxt_state;
  logic skip_ff, nxt_skip;
  logic discard_ff, nxt_discard;
  logic [1:0] flag_ff, nxt_flag;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [1:0] ext_rise;
  logic [1:0] wb_clr;
  logic [1:0] interrupt_control_reg_one;
  logic ext0_irq_enable_bit, ext1_irq_enable_bit;
  logic [1:0] instr_clr;
  logic fetch_ok, imm_ok;

  assign ext0_irq_enable_bit = interrupt_control_reg_one[CTRL_EN0_BIT];
  assign ext1_irq_enable_bit = interrupt_control_reg_one[CTRL_EN1_BIT];

  // ----------------------------------------------------------------
  // request pins and register slave
  // ----------------------------------------------------------------
  sci_pin_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({ext1_pin_i, ext0_pin_i}),
    .rise_o(ext_rise)
  );

  sci_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .flags_i(flag_ff),
    .skip_cnt_i(cnt_ff),
    .en_o(interrupt_control_reg_one),
    .flag_clr_o(wb_clr)
  );

  // ----------------------------------------------------------------
  // sequencer: decide skip, drop the skipped word
  // ----------------------------------------------------------------
  always_comb begin
    fetch_ok = instr_valid_i && state_ff == ST_FETCH;
    imm_ok = instr_valid_i && state_ff == ST_IMM;
    nxt_state = state_ff;
    nxt_skip = 1'b0;
    nxt_discard = 1'b0;
    instr_clr = 2'h0;
    unique case (state_ff)
      ST_FETCH: begin
        if (instr_valid_i) begin
          if (instr_word_i == OPC_SKIP_IMM_W1) begin
            nxt_state = ST_IMM;
          end else if (instr_word_i == OPC_SKIP_MEM) begin
            nxt_skip = acc_i == mem_nibble_i;
          end else if (instr_word_i == OPC_SKIP_EXT0) begin
            if (!ext0_irq_enable_bit && flag_ff[FLAG0_BIT]) begin
              nxt_skip = 1'b1;
              instr_clr[FLAG0_BIT] = 1'b1;
            end
          end else if (instr_word_i == OPC_SKIP_EXT1) begin
            if (!ext1_irq_enable_bit && flag_ff[FLAG1_BIT]) begin
              nxt_skip = 1'b1;
              instr_clr[FLAG1_BIT] = 1'b1;
            end
          end
        end
      end
      ST_IMM: begin
        if (instr_valid_i) begin
          nxt_state = ST_FETCH;
          if (is_imm_word(instr_word_i)) begin
            nxt_skip = acc_i == imm_of(instr_word_i);
          end
        end
      end
      ST_SKIP: begin
        if (instr_valid_i) begin
          nxt_state = ST_FETCH;
          nxt_discard = 1'b1;
        end
      end
      default: nxt_state = ST_FETCH;
    endcase
    if (nxt_skip) begin
      nxt_state = ST_SKIP;
    end
    nxt_cnt = nxt_skip ? cnt_ff + 8'h01 : cnt_ff;
  end

  // ----------------------------------------------------------------
  // request flags: a new request wins over any clear
  // ----------------------------------------------------------------
  always_comb begin
    nxt_flag = (flag_ff & ~(instr_clr | wb_clr)) | ext_rise;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_FETCH;
      skip_ff <= 1'b0;
      discard_ff <= 1'b0;
      flag_ff <= FLAGS_RST;
      cnt_ff <= CNT_RST;
    end else begin
      state_ff <= nxt_state;
      skip_ff <= nxt_skip;
      discard_ff <= nxt_discard;
      flag_ff <= nxt_flag;
      cnt_ff <= nxt_cnt;
    end
  end

  assign skip_o = skip_ff;
  assign discard_o = discard_ff;
  assign ext0_request_flag_o = flag_ff[FLAG0_BIT];
  assign ext1_request_flag_o = flag_ff[FLAG1_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_imm_equal;
    @(posedge clk_i) disable iff (rst_i)
    imm_ok && is_imm_word(instr_word_i) && acc_i == imm_of(instr_word_i)
    |=> skip_o && state_ff == ST_SKIP;
  endproperty
  a_imm_equal: assert property (p_imm_equal)
    else $error("equal immediate did not skip");

  property p_imm_differ;
    @(posedge clk_i) disable iff (rst_i)
    imm_ok && acc_i != imm_of(instr_word_i) |=> !skip_o && state_ff == ST_FETCH;
  endproperty
  a_imm_differ: assert property (p_imm_differ)
    else $error("differing immediate skipped");

  property p_imm_follows;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_IMM_W1 |=> state_ff == ST_IMM && !skip_o;
  endproperty
  a_imm_follows: assert property (p_imm_follows)
    else $error("immediate word not awaited");

  property p_mem_equal;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_MEM && acc_i == mem_nibble_i
    |=> skip_o ##1 (state_ff == ST_SKIP || discard_o);
  endproperty
  a_mem_equal: assert property (p_mem_equal)
    else $error("equal memory did not skip");

  property p_mem_differ;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_MEM && acc_i != mem_nibble_i |=> !skip_o;
  endproperty
  a_mem_differ: assert property (p_mem_differ)
    else $error("differing memory skipped");

  property p_ext0_skip;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT0 && !ext0_irq_enable_bit
    && flag_ff[FLAG0_BIT] && !ext_rise[FLAG0_BIT]
    |=> skip_o && !ext0_request_flag_o;
  endproperty
  a_ext0_skip: assert property (p_ext0_skip)
    else $error("flag0 test did not skip and clear");

  property p_ext0_nop;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT0 && ext0_irq_enable_bit && !wb_clr[FLAG0_BIT]
    |=> !skip_o && ext0_request_flag_o == ($past(flag_ff[FLAG0_BIT]) | $past(ext_rise[0]));
  endproperty
  a_ext0_nop: assert property (p_ext0_nop)
    else $error("enabled flag0 test acted");

  property p_ext1_skip;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT1 && !ext1_irq_enable_bit
    && flag_ff[FLAG1_BIT] && !ext_rise[FLAG1_BIT]
    |=> skip_o && !ext1_request_flag_o;
  endproperty
  a_ext1_skip: assert property (p_ext1_skip)
    else $error("flag1 test did not skip and clear");

  property p_flag_zero;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT0 && !flag_ff[FLAG0_BIT] |=> !skip_o;
  endproperty
  a_flag_zero: assert property (p_flag_zero)
    else $error("clear flag0 caused a skip");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    ext_rise[FLAG0_BIT] |=> ext0_request_flag_o;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("new request lost");

  property p_flag1_zero;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT1 && !flag_ff[FLAG1_BIT] |=> !skip_o;
  endproperty
  a_flag1_zero: assert property (p_flag1_zero)
    else $error("clear flag1 caused a skip");

  property p_ext1_nop;
    @(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT1 && ext1_irq_enable_bit && !wb_clr[FLAG1_BIT]
    |=> !skip_o && ext1_request_flag_o == ($past(flag_ff[FLAG1_BIT]) | $past(ext_rise[1]));
  endproperty
  a_ext1_nop: assert property (p_ext1_nop)
    else $error("enabled flag1 test acted");

  // the word after a skip is dropped, never executed
  property p_discard;
    @(posedge clk_i) disable iff (rst_i)
    state_ff == ST_SKIP && instr_valid_i |=> discard_o && !skip_o && state_ff == ST_FETCH;
  endproperty
  a_discard: assert property (p_discard)
    else $error("skipped word not dropped");

  property p_idle_quiet;
    @(posedge clk_i) disable iff (rst_i)
    !instr_valid_i |=> !skip_o && !discard_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("outcome pulse without a word");

  property p_cnt_step;
    @(posedge clk_i) disable iff (rst_i)
    skip_o |-> cnt_ff == $past(cnt_ff) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("skip count did not step");

  c_imm_skip: cover property (@(posedge clk_i) disable iff (rst_i)
    imm_ok && acc_i == imm_of(instr_word_i) ##1 skip_o);
  c_mem_skip: cover property (@(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_MEM ##1 skip_o);
  c_ext0_skip: cover property (@(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT0 ##1 skip_o);
  c_ext1_skip: cover property (@(posedge clk_i) disable iff (rst_i)
    fetch_ok && instr_word_i == OPC_SKIP_EXT1 ##1 skip_o);
  c_discard: cover property (@(posedge clk_i) disable iff (rst_i)
    skip_o ##[1:4] discard_o);

endmodule : sci_core
`default_nettype wire

// [sci_prog_mem.sv]
// program memory model streaming queued instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module sci_prog_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [17:0] load_dat_i,
  input wire logic stall_i,
  output logic valid_o,
  output logic [9:0] word_o,
  output logic [3:0] acc_o,
  output logic [3:0] mem_o,
  output logic empty_o
);
  logic [17:0] q[$];
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      {acc_o, mem_o, word_o} <= '0;
      empty_o <= 1'b1;
      q.delete();
    end else begin
      if (load_i) q.push_back(load_dat_i);
      if (q.size() != 0 && !stall_i) begin
        {acc_o, mem_o, word_o} <= q.pop_front();
        valid_o <= 1'b1;
        empty_o <= 1'b0;
      end else begin
        // idle lines show the inverse of the last value
        {acc_o, mem_o, word_o} <= ~{acc_o, mem_o, word_o};
        valid_o <= 1'b0;
        empty_o <= (q.size() == 0);
      end
    end
  end
endmodule : sci_prog_mem
`default_nettype wire

// [testbench.sv]
// self-checking bench for the skip/compare instruction core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); n_errors++; end end
module testbench;
  import sci_pkg::*;
  logic clk_i = 0, rst_i = 1, load = 0, stall = 0, e0 = 0, e1 = 0;
  logic cyc = 0, stb = 0, we = 0, pend = 0, skip_pend = 0;
  logic [3:0] adr = 0, sel = 0, acc, mem, a, m;
  logic [31:0] dat = 0, rd, dat_o;
  logic [17:0] load_dat = 0;
  logic valid, skip_o, discard_o, f0, f1, ack_o, empty;
  logic [9:0] word;
  logic [1:0] exp_q[$];
  logic [1:0] e, sd;
  int n_errors = 0, samples_checked = 0, n_skips = 0, seed, i, k;

  sci_prog_mem pmem (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .load_dat_i(load_dat),
    .stall_i(stall), .valid_o(valid), .word_o(word), .acc_o(acc), .mem_o(mem),
    .empty_o(empty));
  sci_core uut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(valid), .instr_word_i(word),
    .acc_i(acc), .mem_nibble_i(mem), .ext0_pin_i(e0), .ext1_pin_i(e1), .skip_o(skip_o),
    .discard_o(discard_o), .ext0_request_flag_o(f0), .ext1_request_flag_o(f1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= d; sel <= 4'hF;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    if (n >= 20) n_errors++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [3:0] ad, input logic [31:0] ex);
    wb(1'b0, ad, 32'h0);
    `CHK("register", ex, rd)
  endtask : rchk

  task automatic put(input logic [9:0] w, input logic [3:0] av, input logic [3:0] mv,
                     input logic sk);
    @(posedge clk_i);
    load <= 1'b1; load_dat <= {av, mv, w}; stall <= ($urandom % 4) == 0;
    if (skip_pend) begin
      exp_q.push_back(2'b01);
      skip_pend = 1'b0;
    end else begin
      exp_q.push_back({sk, 1'b0});
      skip_pend = sk;
      n_skips += sk;
    end
  endtask : put

  task automatic drain;
    int n;
    n = 0;
    @(posedge clk_i);
    load <= 1'b0; stall <= 1'b0;
    do begin @(posedge clk_i); n++; end while (empty !== 1'b1 && n < 200);
    repeat (3) @(posedge clk_i);
    if (n >= 200) n_errors++;
  endtask : drain

  task automatic pin(input int j);
    @(posedge clk_i);
    if (j != 0) e1 <= 1'b1; else e0 <= 1'b1;
    repeat (2) @(posedge clk_i);
    e0 <= 1'b0; e1 <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : pin

  function automatic logic flag(input int j);
    return (j != 0) ? f1 : f0;
  endfunction : flag

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // monitor: one note per word taken
  // ----------------------------------------------------------------
  always @(posedge clk_i) pend <= valid && !rst_i;
  always @(negedge clk_i) begin
    if (pend) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 2'b00;
      sd = {skip_o, discard_o};
      `CHK("skip_discard", e, sd)
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(32'h27C64667);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ADR_CTRL, 32'h0);
    rchk(ADR_FLAGS, 32'h0);
    rchk(ADR_SKIPCNT, 32'h0);
    rchk(4'hC, 32'h0);
    for (k = 0; k < 16; k++) begin
      a = ($urandom % 2) ? 4'(k) : 4'($urandom);
      put(OPC_SKIP_IMM_W1, a, 4'($urandom), 1'b0);
      put({IMM_PREFIX, 4'(k)}, a, 4'($urandom), a == 4'(k));
      put(10'h000, 4'($urandom), 4'($urandom), 1'b0);
    end
    put(OPC_SKIP_IMM_W1, 4'h5, 4'h0, 1'b0);
    put(10'h0A5, 4'h5, 4'h0, 1'b0);
    drain();
    for (k = 0; k < 24; k++) begin
      a = 4'($urandom);
      m = ($urandom % 2) ? a : 4'($urandom);
      put(OPC_SKIP_MEM, a, m, a == m);
      put(10'h000, 4'($urandom), 4'($urandom), 1'b0);
    end
    drain();
    for (i = 0; i < 2; i++) begin
      pin(i);
      `CHK("flag_set", 1'b1, flag(i))
      wb(1'b1, ADR_CTRL, 32'(1 << i));
      put(i ? OPC_SKIP_EXT1 : OPC_SKIP_EXT0, 4'h0, 4'h0, 1'b0);
      put(10'h000, 4'h0, 4'h0, 1'b0);
      drain();
      `CHK("flag_kept", 1'b1, flag(i))
      wb(1'b1, ADR_CTRL, 32'h0);
      put(i ? OPC_SKIP_EXT1 : OPC_SKIP_EXT0, 4'h0, 4'h0, 1'b1);
      put(10'h000, 4'h0, 4'h0, 1'b0);
      drain();
      `CHK("flag_cleared", 1'b0, flag(i))
      put(i ? OPC_SKIP_EXT1 : OPC_SKIP_EXT0, 4'h0, 4'h0, 1'b0);
      drain();
      `CHK("flag_clear_kept", 1'b0, flag(i))
    end
    pin(0);
    pin(1);
    rchk(ADR_FLAGS, 32'h3);
    wb(1'b1, ADR_FLAGS, 32'h1);
    rchk(ADR_FLAGS, 32'h2);
    wb(1'b1, ADR_FLAGS, 32'h2);
    rchk(ADR_FLAGS, 32'h0);
    wb(1'b1, ADR_CTRL, ($urandom & 32'hFFFFFFFC) | 32'h3);
    rchk(ADR_CTRL, 32'h3);
    wb(1'b1, ADR_CTRL, 32'h0);
    rchk(ADR_SKIPCNT, 32'(n_skips % 256));
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
